//--- verilog/if_digitizer_consts.vh
// Constants for the IF digitizer configuration register bank.
// Assumes inclusion by bare name from the design files.
`ifndef IF_DIGITIZER_CONSTS_VH
`define IF_DIGITIZER_CONSTS_VH

// ****************************************
// Register addresses
// ****************************************
`define ADDR_W 13
`define ADDR_STANDBY_CONTROL 13'h0000
`define ADDR_OSCILLATOR_BIAS 13'h0001
`define ADDR_FACTORY_TEST 13'h0002
`define ADDR_FRONT_PAD_ON_GAIN_HIGH 13'h0003
`define ADDR_GAIN_LOW 13'h0004
`define ADDR_GAIN_LOOP_TIMING 13'h0005
`define ADDR_GAIN_LOOP_CONTROL 13'h0006
`define ADDR_DECIMATION_SELECT 13'h0007
`define ADDR_LAST 13'h0007

// ****************************************
// Reset values and writable bit masks
// ****************************************
`define RST_STANDBY_CONTROL 8'hff
`define RST_OSCILLATOR_BIAS 8'h00
`define RST_FACTORY_TEST 8'h00
`define RST_FRONT_PAD_ON_GAIN_HIGH 8'h00
`define RST_GAIN_LOW 8'h00
`define RST_GAIN_LOOP_TIMING 8'h00
`define RST_GAIN_LOOP_CONTROL 8'h00
`define RST_DECIMATION_SELECT 8'h04
`define MASK_FULL 8'hff
`define MASK_OSCILLATOR_BIAS 8'h0f
`define MASK_DECIMATION_SELECT 8'h1f

// ****************************************
// Field positions
// ****************************************
`define OSC_BIAS_MSB 3
`define OSC_BIAS_LSB 2
`define FRONT_PAD_BIT 7
`define DIGITAL_GAIN_BIT 7
`define OVERLOAD_MSB 6
`define OVERLOAD_LSB 4
`define FAST_LOOP_BIT 3
`define DECIM_RATIO_BIT 4

// ****************************************
// Decimation bases and serial framing
// ****************************************
`define DECIM_BASE_NORMAL 10'd60
`define DECIM_BASE_ALT 10'd48
`define HDR_LAST_BIT 4'hf
`define BYTE_LAST_BIT 4'h7

`endif

//--- verilog/reg_word_store.v
// Eight-word store of configuration bytes with masked writes.
// Assumes one write port and one registered read port on core_clk.
`timescale 1ns/100ps
`default_nettype none

module reg_word_store #(
  parameter WORDS = 8
) (
  input wire core_clk,
  input wire rst_b,
  input wire wr_en,
  input wire [2:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [2:0] rd_addr,
  output reg [7:0] rd_data,
  output wire [8*WORDS-1:0] all_words
);
`include "if_digitizer_consts.vh"

  // ****************************************
  // Per-word reset value and mask
  // ****************************************
  function [7:0] reset_value;
    input integer idx;
    begin
      case (idx)
        0: reset_value = `RST_STANDBY_CONTROL;
        1: reset_value = `RST_OSCILLATOR_BIAS;
        2: reset_value = `RST_FACTORY_TEST;
        3: reset_value = `RST_FRONT_PAD_ON_GAIN_HIGH;
        4: reset_value = `RST_GAIN_LOW;
        5: reset_value = `RST_GAIN_LOOP_TIMING;
        6: reset_value = `RST_GAIN_LOOP_CONTROL;
        7: reset_value = `RST_DECIMATION_SELECT;
        default: reset_value = 8'h00;
      endcase
    end
  endfunction

  function [7:0] write_mask;
    input integer idx;
    begin
      case (idx)
        1: write_mask = `MASK_OSCILLATOR_BIAS;
        7: write_mask = `MASK_DECIMATION_SELECT;
        default: write_mask = `MASK_FULL;
      endcase
    end
  endfunction

  // ****************************************
  // Storage words
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < WORDS; gi = gi + 1) begin : g_word
      localparam [2:0] WORD_IDX = gi;
      reg [7:0] word;
      always @(posedge core_clk) begin
        if (!rst_b) begin
          word <= reset_value(gi);
        end else if (wr_en && (wr_addr == WORD_IDX)) begin
          word <= wr_data & write_mask(gi);
        end
      end
      assign all_words[8*gi+7:8*gi] = word;
    end
  endgenerate

  // ****************************************
  // Registered read
  // ****************************************
  always @(posedge core_clk) begin
    if (!rst_b) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= all_words[8*rd_addr +: 8];
    end
  end

endmodule

`default_nettype wire

//--- verilog/if_digitizer_config_regs.v
// Low-address configuration register bank of an IF digitizer, reached over
// a three-wire serial port.
// Assumes the serial pins are synchronous to core_clk and that each serial
// clock half period lasts at least four core_clk cycles.
//
// Summary of operation
// - Serial port writes and reads back registers
// - Standby byte at 0x00 resets to 0xff
// - Bias bits [3:2] choose oscillator current
// - Bit 7 of 0x03 inserts front attenuation
// - Fifteen-bit gain word over 0x03 and 0x04
// - Bits [7:4] of 0x05 set attack bandwidth
// - Bits [3:0] of 0x05 set decay time
// - Bit 7 of 0x06 enables digital gain stage
// - Bits [6:4] of 0x06 set overload rate
// - Bit 3 of 0x06 selects fast loop
// - Bits [2:0] of 0x06 enable and set reference
// - Decimation is 60 or 48 times M+1
// - Three pins: clock, data, select
`timescale 1ns/100ps
`default_nettype none

module if_digitizer_config_regs (
  input wire core_clk,
  input wire rst_b,
  input wire serial_clock_in,
  input wire serial_select_in,
  input wire serial_data_in,
  output reg serial_data_out,
  output reg serial_data_oe,
  output reg [7:0] sleep_bits,
  output reg [1:0] osc_bias_current,
  output reg [1:0] converter_bias_reserved,
  output reg [7:0] factory_test_bits,
  output reg front_pad_on,
  output reg [14:0] gain_word,
  output reg [3:0] attack_bw,
  output reg [3:0] decay_time,
  output reg digital_gain_stage_on,
  output reg [2:0] overload_update_rate,
  output reg fast_loop,
  output reg [2:0] loop_reference_level,
  output reg loop_enabled,
  output reg decim_ratio_alt,
  output reg [3:0] decim_m,
  output reg [9:0] decimation_factor
);
`include "if_digitizer_consts.vh"

  // ****************************************
  // States
  // ****************************************
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_HEADER = 2'b01;
  localparam [1:0] ST_WRITE = 2'b10;
  localparam [1:0] ST_READ = 2'b11;

  reg [1:0] state;
  reg [1:0] next_state;
  reg clk_q;
  reg [3:0] bit_cnt;
  reg [15:0] hdr_shift;
  reg [7:0] wr_shift;
  reg [7:0] rd_shift;
  reg [`ADDR_W-1:0] cur_addr;
  reg [1:0] bytes_left;
  reg wr_en;
  reg [2:0] wr_addr;
  reg [7:0] wr_data;

  wire clk_rise;
  wire clk_fall;
  wire addr_mapped;
  wire [7:0] rd_data;
  wire [63:0] words;
  wire [7:0] rd_byte;
  wire [15:0] hdr_next;
  wire [7:0] wr_next;
  wire [9:0] decim_base;
  wire [4:0] m_plus_one;
  wire [14:0] decim_product;

  // ****************************************
  // Serial clock edges
  // ****************************************
  assign clk_rise = serial_select_in & serial_clock_in & ~clk_q;
  assign clk_fall = serial_select_in & ~serial_clock_in & clk_q;

  always @(posedge core_clk) begin
    if (!rst_b) begin
      clk_q <= 1'b0;
    end else begin
      clk_q <= serial_clock_in;
    end
  end

  // ****************************************
  // Address decode
  // ****************************************
  function mapped;
    input [`ADDR_W-1:0] a;
    begin
      mapped = (a <= `ADDR_LAST);
    end
  endfunction

  assign addr_mapped = mapped(cur_addr);
  assign rd_byte = addr_mapped ? rd_data : 8'h00;
  assign hdr_next = {hdr_shift[14:0], serial_data_in};
  assign wr_next = {wr_shift[6:0], serial_data_in};

  // ****************************************
  // Frame state machine
  // ****************************************
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (serial_select_in) begin
          next_state = ST_HEADER;
        end
      end
      ST_HEADER: begin
        if (clk_rise && (bit_cnt == `HDR_LAST_BIT)) begin
          next_state = hdr_next[15] ? ST_READ : ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (clk_rise && (bit_cnt == `BYTE_LAST_BIT) && (bytes_left == 2'b00)) begin
          next_state = ST_HEADER;
        end
      end
      ST_READ: begin
        if (clk_rise && (bit_cnt == `BYTE_LAST_BIT) && (bytes_left == 2'b00)) begin
          next_state = ST_HEADER;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (!serial_select_in) begin
      next_state = ST_IDLE;
    end
  end

  always @(posedge core_clk) begin
    if (!rst_b) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // Shifting, counting and write strobes
  // ****************************************
  always @(posedge core_clk) begin
    if (!rst_b) begin
      bit_cnt <= 4'h0;
      hdr_shift <= 16'h0000;
      wr_shift <= 8'h00;
      cur_addr <= {`ADDR_W{1'b0}};
      bytes_left <= 2'b00;
      wr_en <= 1'b0;
      wr_addr <= 3'h0;
      wr_data <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      if (!serial_select_in || state == ST_IDLE) begin
        bit_cnt <= 4'h0;
      end else if (clk_rise) begin
        case (state)
          ST_HEADER: begin
            hdr_shift <= hdr_next;
            if (bit_cnt == `HDR_LAST_BIT) begin
              bit_cnt <= 4'h0;
              bytes_left <= hdr_next[14:13];
              cur_addr <= hdr_next[`ADDR_W-1:0];
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          ST_WRITE: begin
            wr_shift <= wr_next;
            if (bit_cnt == `BYTE_LAST_BIT) begin
              bit_cnt <= 4'h0;
              wr_en <= addr_mapped;
              wr_addr <= cur_addr[2:0];
              wr_data <= wr_next;
              cur_addr <= cur_addr + {{(`ADDR_W-1){1'b0}}, 1'b1};
              bytes_left <= bytes_left - 2'b01;
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          ST_READ: begin
            if (bit_cnt == `BYTE_LAST_BIT) begin
              bit_cnt <= 4'h0;
              cur_addr <= cur_addr + {{(`ADDR_W-1){1'b0}}, 1'b1};
              bytes_left <= bytes_left - 2'b01;
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          default: begin
            bit_cnt <= 4'h0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Read data onto the shared data line
  // ****************************************
  always @(posedge core_clk) begin
    if (!rst_b) begin
      rd_shift <= 8'h00;
      serial_data_out <= 1'b0;
      serial_data_oe <= 1'b0;
    end else begin
      serial_data_oe <= serial_select_in && (state == ST_READ);
      if (state != ST_READ) begin
        serial_data_out <= 1'b0;
      end else if (clk_fall) begin
        if (bit_cnt == 4'h0) begin
          rd_shift <= {rd_byte[6:0], 1'b0};
          serial_data_out <= rd_byte[7];
        end else begin
          rd_shift <= {rd_shift[6:0], 1'b0};
          serial_data_out <= rd_shift[7];
        end
      end
    end
  end

  // ****************************************
  // Register storage
  // ****************************************
  reg_word_store #(
    .WORDS(8)
  ) u_store (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(cur_addr[2:0]),
    .rd_data(rd_data),
    .all_words(words)
  );

  // ****************************************
  // Decimation factor
  // ****************************************
  assign decim_base = words[8*7+`DECIM_RATIO_BIT] ? `DECIM_BASE_ALT : `DECIM_BASE_NORMAL;
  assign m_plus_one = {1'b0, words[8*7+3:8*7]} + 5'h01;
  assign decim_product = {5'h00, decim_base} * {10'h000, m_plus_one};

  // ****************************************
  // Power control output
  // ****************************************
  always @(posedge core_clk) begin
    if (!rst_b) begin
      sleep_bits <= `RST_STANDBY_CONTROL;
    end else begin
      sleep_bits <= words[7:0];
    end
  end

  // ****************************************
  // Bias and test outputs
  // ****************************************
  always @(posedge core_clk) begin
    if (!rst_b) begin
      osc_bias_current <= 2'b00;
      converter_bias_reserved <= 2'b00;
      factory_test_bits <= `RST_FACTORY_TEST;
    end else begin
      osc_bias_current <= words[8+`OSC_BIAS_MSB:8+`OSC_BIAS_LSB];
      converter_bias_reserved <= words[9:8];
      factory_test_bits <= words[23:16];
    end
  end

  // ****************************************
  // Attenuator and gain word outputs
  // ****************************************
  always @(posedge core_clk) begin
    if (!rst_b) begin
      front_pad_on <= 1'b0;
      gain_word <= 15'h0000;
    end else begin
      front_pad_on <= words[24+`FRONT_PAD_BIT];
      gain_word <= {words[30:24], words[39:32]};
    end
  end

  // ****************************************
  // Gain loop outputs
  // ****************************************
  always @(posedge core_clk) begin
    if (!rst_b) begin
      attack_bw <= 4'h0;
      decay_time <= 4'h0;
      digital_gain_stage_on <= 1'b0;
      overload_update_rate <= 3'h0;
      fast_loop <= 1'b0;
      loop_reference_level <= 3'h0;
      loop_enabled <= 1'b0;
    end else begin
      attack_bw <= words[47:44];
      decay_time <= words[43:40];
      digital_gain_stage_on <= words[48+`DIGITAL_GAIN_BIT];
      overload_update_rate <= words[48+`OVERLOAD_MSB:48+`OVERLOAD_LSB];
      fast_loop <= words[48+`FAST_LOOP_BIT];
      loop_reference_level <= words[50:48];
      loop_enabled <= (words[50:48] != 3'h0);
    end
  end

  // ****************************************
  // Decimation outputs
  // ****************************************
  always @(posedge core_clk) begin
    if (!rst_b) begin
      decim_ratio_alt <= 1'b0;
      decim_m <= 4'h4;
      decimation_factor <= 10'd300;
    end else begin
      decim_ratio_alt <= words[8*7+`DECIM_RATIO_BIT];
      decim_m <= words[59:56];
      decimation_factor <= decim_product[9:0];
    end
  end

endmodule

`default_nettype wire

//--- dv/cfg_regs_asserts.sv
// Checker for the configuration register bank port behaviour.
// Assumes binding to the top module; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module cfg_regs_asserts (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic serial_clock_in,
  input wire logic serial_select_in,
  input wire logic serial_data_out,
  input wire logic serial_data_oe,
  input wire logic [7:0] sleep_bits,
  input wire logic [14:0] gain_word,
  input wire logic [2:0] loop_reference_level,
  input wire logic loop_enabled,
  input wire logic decim_ratio_alt,
  input wire logic [3:0] decim_m,
  input wire logic [9:0] decimation_factor
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic sck_q1;
  logic sck_q2;
  logic [2:0] idle_cnt;
  always @(posedge core_clk) begin
    sck_q1 <= serial_clock_in;
    sck_q2 <= sck_q1;
    if (!rst_b || serial_select_in) idle_cnt <= 3'h0;
    else if (idle_cnt != 3'h7) idle_cnt <= idle_cnt + 3'h1;
  end
  property p_reset_vals;
    $rose(rst_b) |-> sleep_bits == 8'hff && decim_m == 4'h4 && decimation_factor == 10'd300
      && gain_word == 15'h0 && !serial_data_oe;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
  property p_decim;
    $stable({decim_ratio_alt, decim_m}) |->
      decimation_factor == (decim_ratio_alt ? 10'd48 : 10'd60) * ({6'h0, decim_m} + 10'd1);
  endproperty
  a_decim: assert property (p_decim) else $error("decimation factor wrong");
  property p_loop_en;
    $stable(loop_reference_level) |-> loop_enabled == (loop_reference_level != 3'h0);
  endproperty
  a_loop_en: assert property (p_loop_en) else $error("loop enable wrong");
  property p_oe_drop;
    !serial_select_in [*2] |-> !serial_data_oe;
  endproperty
  a_oe_drop: assert property (p_oe_drop) else $error("data driven while idle");
  property p_oe_rise;
    $rose(serial_data_oe) |-> serial_select_in && serial_clock_in;
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("drive began off a rising edge");
  property p_dout_hold;
    serial_data_oe && $past(serial_data_oe) && sck_q1 == sck_q2 |-> $stable(serial_data_out);
  endproperty
  a_dout_hold: assert property (p_dout_hold) else $error("read bit moved");
  property p_cfg_src;
    $changed({sleep_bits, gain_word}) |-> $past(serial_select_in, 3);
  endproperty
  a_cfg_src: assert property (p_cfg_src) else $error("setting moved outside frame");
  property p_idle_quiet;
    idle_cnt == 3'h7 |-> $stable({sleep_bits, gain_word, decim_m, loop_reference_level});
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("setting moved while idle");
  c_read: cover property ($rose(serial_data_oe));
  c_write: cover property ($changed(sleep_bits));
  c_alt: cover property ($rose(decim_ratio_alt));
endmodule
bind if_digitizer_config_regs cfg_regs_asserts chk (.core_clk(core_clk), .rst_b(rst_b),
  .serial_clock_in(serial_clock_in), .serial_select_in(serial_select_in),
  .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
  .sleep_bits(sleep_bits), .gain_word(gain_word), .loop_reference_level(loop_reference_level),
  .loop_enabled(loop_enabled), .decim_ratio_alt(decim_ratio_alt), .decim_m(decim_m),
  .decimation_factor(decimation_factor));
`default_nettype wire

//--- dv/serial_host.sv
// Host model driving the three-wire serial port.
// Assumes core_clk as timebase; half serial period is five cycles.
`timescale 1ns/100ps
`default_nettype none
module serial_host (
  input wire logic core_clk,
  input wire logic serial_data_out,
  input wire logic serial_data_oe,
  output logic serial_clock_in,
  output logic serial_select_in,
  output wire logic serial_data_in
);
  // ****************************************
  // Frame driver
  // ****************************************
  logic drv = 1'b0;
  logic host_on = 1'b1;
  logic released = 1'b0;
  initial serial_clock_in = 1'b0;
  initial serial_select_in = 1'b0;
  assign serial_data_in = serial_data_oe ? serial_data_out : (host_on ? drv : released);
  always @(posedge core_clk) released <= ~serial_data_in;
  task automatic half();
    repeat (5) @(posedge core_clk);
    #1;
  endtask
  task automatic xfer(input logic rd_op, input logic [1:0] nm1, input logic [12:0] addr,
      input logic [31:0] wd, input int stop_at, output logic [31:0] rdat);
    logic [15:0] hdr;
    int nb;
    int i;
    hdr = {rd_op, nm1, addr};
    nb = 8 * (nm1 + 1);
    rdat = 32'h0;
    @(posedge core_clk);
    #1;
    serial_select_in = 1'b1;
    for (i = 0; i < 16 + nb && i != stop_at; i++) begin
      host_on = !(rd_op && i >= 16);
      drv = (i < 16) ? hdr[15 - i] : wd[nb - 1 - (i - 16)];
      half();
      if (!host_on) rdat = {rdat[30:0], serial_data_in};
      serial_clock_in = 1'b1;
      half();
      serial_clock_in = 1'b0;
    end
    half();
    serial_select_in = 1'b0;
    host_on = 1'b1;
    half();
  endtask
endmodule
`default_nettype wire

//--- dv/test_if_digitizer_config_regs.sv
// Self-checking bench for the configuration register bank.
// Assumes the serial host model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module test_if_digitizer_config_regs;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  wire sck, sel, sdi, sdo, soe, pad, dgs, fast, len, alt;
  wire [1:0] osc, conv;
  wire [7:0] sleep_bits;
  wire [7:0] ftb;
  wire [14:0] gain;
  wire [3:0] atk, dcy, dm;
  wire [2:0] ovl, ref_lvl;
  wire [9:0] fac;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  int i;
  logic [31:0] rd;
  logic [28:0] r;
  logic [28:0] rows [0:8] = '{
    {13'h0, 8'h5a, 8'h5a},
    {13'h1, 8'hfc, 8'h0c},
    {13'h2, 8'h00, 8'h00},
    {13'h3, 8'hc5, 8'hc5},
    {13'h4, 8'h3c, 8'h3c},
    {13'h5, 8'ha7, 8'ha7},
    {13'h6, 8'hfd, 8'hfd},
    {13'h7, 8'hff, 8'h1f},
    {13'h9, 8'h55, 8'h00}};
  serial_host host (.core_clk(core_clk), .serial_data_out(sdo), .serial_data_oe(soe),
    .serial_clock_in(sck), .serial_select_in(sel), .serial_data_in(sdi));
  if_digitizer_config_regs dut (.core_clk(core_clk), .rst_b(rst_b), .serial_clock_in(sck),
    .serial_select_in(sel), .serial_data_in(sdi), .serial_data_out(sdo), .serial_data_oe(soe),
    .sleep_bits(sleep_bits), .osc_bias_current(osc), .converter_bias_reserved(conv),
    .factory_test_bits(ftb), .front_pad_on(pad), .gain_word(gain), .attack_bw(atk),
    .decay_time(dcy), .digital_gain_stage_on(dgs), .overload_update_rate(ovl),
    .fast_loop(fast), .loop_reference_level(ref_lvl), .loop_enabled(len),
    .decim_ratio_alt(alt), .decim_m(dm), .decimation_factor(fac));
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task chk_rd(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected read at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_port(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected port at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [12:0] a, input logic [7:0] d);
    host.xfer(1'b0, 2'd0, a, {24'h0, d}, 99, rd);
  endtask
  task report_and_stop();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    host.xfer(1'b1, 2'd3, 13'h0, 32'h0, 99, rd);
    chk_rd(rd, 32'hff000000);
    host.xfer(1'b1, 2'd3, 13'h4, 32'h0, 99, rd);
    chk_rd(rd, 32'h00000004);
    chk_port({22'h0, fac}, 32'd300);
    $display("reset test done");
    for (i = 0; i < 9; i++) begin
      r = rows[i];
      wr(r[28:16], r[15:8]);
      host.xfer(1'b1, 2'd0, r[28:16], 32'h0, 99, rd);
      chk_rd(rd, {24'h0, r[7:0]});
    end
    chk_port({24'h0, sleep_bits}, 32'h5a);
    chk_port({28'h0, osc, conv}, 32'hc);
    chk_port({24'h0, ftb}, 32'h0);
    chk_port({16'h0, pad, gain}, 32'hc53c);
    chk_port({24'h0, atk, dcy}, 32'ha7);
    chk_port({24'h0, dgs, ovl, fast, ref_lvl}, 32'hfd);
    chk_port({17'h0, alt, dm, fac}, {17'h0, 1'b1, 4'hf, 10'd768});
    $display("row test done");
    for (i = 0; i < 6; i++) begin
      wr(13'h6, i[7:0]);
      chk_port({31'h0, len}, {31'h0, i != 0});
    end
    host.xfer(1'b0, 2'd1, 13'h6, 32'h0000000b, 99, rd);
    chk_port({21'h0, len, fac}, {21'h0, 1'b0, 10'd720});
    host.xfer(1'b0, 2'd0, 13'h4, 32'h000000ff, 20, rd);
    host.xfer(1'b1, 2'd0, 13'h4, 32'h0, 99, rd);
    chk_rd(rd, 32'h3c);
    $display("frame test done");
    @(posedge core_clk);
    #1;
    rst_b = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    chk_port({14'h0, sleep_bits, fac}, {14'h0, 8'hff, 10'd300});
    host.xfer(1'b1, 2'd0, 13'h3, 32'h0, 99, rd);
    chk_rd(rd, 32'h0);
    $display("second reset test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
